// file: design/rpp_defs.vh
/*
 * Constants for the receive-port paging and status block.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef RPP_DEFS_VH
`define RPP_DEFS_VH

`define RPP_ADDR_PAGE_SEL 8'h4C
`define RPP_ADDR_STATUS_ONE 8'h4D
`define RPP_ADDR_PAGED_A 8'h4A
`define RPP_ADDR_PAGED_B 8'h4B
`define RPP_ADDR_PAGED_LO 8'h4D
`define RPP_ADDR_PAGED_HI 8'h7F
`define RPP_ADDR_PAGED2_LO 8'hD0
`define RPP_ADDR_PAGED2_HI 8'hDF

`define RPP_SEL_PHYS_BIT 6
`define RPP_SEL_READ_BIT 4
`define RPP_SEL_WEN1_BIT 1
`define RPP_SEL_WEN0_BIT 0

`define RPP_SEL_RST_LOCAL 3'h0
`define RPP_SEL_RST_CC0 3'h1
`define RPP_SEL_RST_CC1 3'h6

`define RPP_STS_PORT_BIT 6
`define RPP_STS_CKSUM_BIT 5
`define RPP_STS_LOCKCHG_BIT 4
`define RPP_STS_ORDER_BIT 3
`define RPP_STS_PARITY_BIT 2
`define RPP_STS_PASS_BIT 1
`define RPP_STS_LOCK_BIT 0

`define RPP_SRC_LOCAL 2'h0
`define RPP_SRC_CC0 2'h1
`define RPP_SRC_CC1 2'h2

`endif

// file: design/rpp_port_paging.v
/*
 * Receive-port paging and first port status register for a two-port
 * link hub. Holds separate paging state for local host and for each
 * control-channel port, routes paged accesses, and keeps status flags.
 * Assumes one-cycle access strobes from register-access logic on the
 * same clock; per-port event toggles and level inputs arrive from other
 * clock domains and are synchronised here.
 */
// Contract
// RULE_01 - Paged addresses route to the port block chosen by paging state.
// RULE_02 - Read-select bit 4 picks port 0 or 1 for paged reads.
// RULE_03 - Write enables bit 1 and bit 0; both set writes both ports.
// RULE_04 - A cleared write enable leaves that port's paged registers unchanged.
// RULE_05 - Read select defaults 0 locally, arriving port for control channel.
// RULE_06 - Control-channel write enable of the arriving port defaults to 1.
// RULE_07 - Each access source keeps its own paging state.
// RULE_08 - Physical port bit 6 reads 0 locally, arriving port remotely.
// RULE_09 - Status bit 6 reports the port chosen by read select.
// RULE_10 - Status bit 5 sets on checksum error, clears on read.
// RULE_11 - Status bit 4 sets on lock change, clears on read.
// RULE_12 - Status bit 3 sets on order error, clears on read.
// RULE_13 - Status bit 2 follows parity count above limit, not read-cleared.
// RULE_14 - Status bit 1 shows the live pass indication.
// RULE_15 - Status bit 0 shows the live receiver lock state.
// RULE_16 - Read clears affect only the port block that supplied data.
`timescale 1ns/1ps
`default_nettype none
`include "rpp_defs.vh"

module rpp_port_paging (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire clk_en_i,
    input wire [1:0] acc_src_i,
    input wire acc_rd_i,
    input wire acc_wr_i,
    input wire [7:0] acc_addr_i,
    input wire [7:0] acc_wdata_i,
    output reg [7:0] acc_rdata_o,
    output wire paged_hit_o,
    output wire [1:0] paged_wr_port_o,
    output wire paged_rd_port_o,
    input wire [1:0] receiver_locked_i,
    input wire [1:0] port_pass_i,
    input wire [1:0] parity_over_limit_i,
    input wire [1:0] ctrl_channel_checksum_i,
    input wire [1:0] ctrl_channel_order_i
);

    // ----------------------------------------------------------------
    // Input synchronisers.
    // ----------------------------------------------------------------
    // Error events are levels toggled per event by the link side, so a
    // change is caught safely across the crossing.
    reg [9:0] sync1_ff;
    reg [9:0] sync2_ff;
    reg [9:0] sync3_ff;
    wire [9:0] raw_in;
    assign raw_in = {ctrl_channel_order_i, ctrl_channel_checksum_i,
                     parity_over_limit_i, port_pass_i, receiver_locked_i};

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_ff <= 10'h000;
            sync2_ff <= 10'h000;
            sync3_ff <= 10'h000;
        end else if (clk_en_i) begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    wire [1:0] lock_s = sync2_ff[1:0];
    wire [1:0] pass_s = sync2_ff[3:2];
    wire [1:0] par_s = sync2_ff[5:4];
    wire [1:0] cks_ev = sync2_ff[7:6] ^ sync3_ff[7:6];
    wire [1:0] ord_ev = sync2_ff[9:8] ^ sync3_ff[9:8];
    wire [1:0] lchg_ev = sync2_ff[1:0] ^ sync3_ff[1:0];

    // ----------------------------------------------------------------
    // Paging state, one set per source.
    // ----------------------------------------------------------------
    reg [2:0] loc_sel_ff;
    reg [2:0] cc0_sel_ff;
    reg [2:0] cc1_sel_ff;
    reg [2:0] cur_sel;
    reg phys_port;

    always @* begin
        case (acc_src_i)
            `RPP_SRC_CC0: begin
                cur_sel = cc0_sel_ff;
                phys_port = 1'b0;
            end
            `RPP_SRC_CC1: begin
                cur_sel = cc1_sel_ff;
                phys_port = 1'b1;  // [RULE_08]
            end
            default: begin
                cur_sel = loc_sel_ff;
                phys_port = 1'b0;  // [RULE_08]
            end
        endcase
    end

    // Field layout inside cur_sel: [2] read select, [1:0] write enables.
    wire rd_port = cur_sel[2];  // [RULE_02]
    wire [1:0] wr_en = cur_sel[1:0];  // [RULE_03]

    wire in_paged = (acc_addr_i == `RPP_ADDR_PAGED_A) ||
                    (acc_addr_i == `RPP_ADDR_PAGED_B) ||
                    ((acc_addr_i >= `RPP_ADDR_PAGED_LO) &&
                     (acc_addr_i <= `RPP_ADDR_PAGED_HI)) ||
                    ((acc_addr_i >= `RPP_ADDR_PAGED2_LO) &&
                     (acc_addr_i <= `RPP_ADDR_PAGED2_HI));  // [RULE_01]

    assign paged_hit_o = in_paged;
    assign paged_rd_port_o = rd_port;  // [RULE_01]
    assign paged_wr_port_o = (acc_wr_i && in_paged) ? wr_en : 2'h0;  // [RULE_04]

    wire sel_wr = acc_wr_i && (acc_addr_i == `RPP_ADDR_PAGE_SEL);
    wire [2:0] new_sel = {acc_wdata_i[`RPP_SEL_READ_BIT],
                          acc_wdata_i[`RPP_SEL_WEN1_BIT],
                          acc_wdata_i[`RPP_SEL_WEN0_BIT]};

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            loc_sel_ff <= `RPP_SEL_RST_LOCAL;  // [RULE_05]
            cc0_sel_ff <= `RPP_SEL_RST_CC0;  // [RULE_05] [RULE_06]
            cc1_sel_ff <= `RPP_SEL_RST_CC1;  // [RULE_05] [RULE_06]
        end else if (clk_en_i && sel_wr) begin
            // Only the accessing source's copy moves. [RULE_07]
            case (acc_src_i)
                `RPP_SRC_CC0: cc0_sel_ff <= new_sel;
                `RPP_SRC_CC1: cc1_sel_ff <= new_sel;
                default: loc_sel_ff <= new_sel;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Per-port status flags.
    // ----------------------------------------------------------------
    wire [1:0] cks_flag;
    wire [1:0] ord_flag;
    wire [1:0] lchg_flag;
    wire sts_rd = acc_rd_i && (acc_addr_i == `RPP_ADDR_STATUS_ONE);
    // Only the block that answered the read is cleared. [RULE_16]
    wire [1:0] rd_clr = sts_rd ? (rd_port ? 2'h2 : 2'h1) : 2'h0;

    rpp_rc_flag #(
        .WIDTH(2)
    ) i_cks_flag (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .set_i(cks_ev),  // [RULE_10]
        .clr_i(rd_clr),
        .flag_o(cks_flag)
    );

    rpp_rc_flag #(
        .WIDTH(2)
    ) i_ord_flag (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .set_i(ord_ev),  // [RULE_12]
        .clr_i(rd_clr),
        .flag_o(ord_flag)
    );

    rpp_rc_flag #(
        .WIDTH(2)
    ) i_lchg_flag (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .set_i(lchg_ev),  // [RULE_11]
        .clr_i(rd_clr),
        .flag_o(lchg_flag)
    );

    // ----------------------------------------------------------------
    // Read data.
    // ----------------------------------------------------------------
    reg [7:0] nxt_rdata;
    always @* begin
        nxt_rdata = 8'h00;
        if (acc_addr_i == `RPP_ADDR_PAGE_SEL) begin
            nxt_rdata[`RPP_SEL_PHYS_BIT] = phys_port;  // [RULE_08]
            nxt_rdata[`RPP_SEL_READ_BIT] = rd_port;
            nxt_rdata[`RPP_SEL_WEN1_BIT] = wr_en[1];
            nxt_rdata[`RPP_SEL_WEN0_BIT] = wr_en[0];
        end else if (acc_addr_i == `RPP_ADDR_STATUS_ONE) begin
            nxt_rdata[`RPP_STS_PORT_BIT] = rd_port;  // [RULE_09]
            nxt_rdata[`RPP_STS_CKSUM_BIT] = cks_flag[rd_port];  // [RULE_10]
            nxt_rdata[`RPP_STS_LOCKCHG_BIT] = lchg_flag[rd_port];  // [RULE_11]
            nxt_rdata[`RPP_STS_ORDER_BIT] = ord_flag[rd_port];  // [RULE_12]
            nxt_rdata[`RPP_STS_PARITY_BIT] = par_s[rd_port];  // [RULE_13]
            nxt_rdata[`RPP_STS_PASS_BIT] = pass_s[rd_port];  // [RULE_14]
            nxt_rdata[`RPP_STS_LOCK_BIT] = lock_s[rd_port];  // [RULE_15]
        end
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_rdata_o <= 8'h00;
        end else if (clk_en_i && acc_rd_i) begin
            acc_rdata_o <= nxt_rdata;
        end
    end

endmodule

// ----------------------------------------------------------------
// Clear-on-read flag bank.
// ----------------------------------------------------------------
// A set in the clearing cycle wins, so an event that lands while the
// old value is being read out is kept for the next read.
module rpp_rc_flag #(
    parameter WIDTH = 2
) (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire clk_en_i,
    input wire [WIDTH-1:0] set_i,
    input wire [WIDTH-1:0] clr_i,
    output wire [WIDTH-1:0] flag_o
);

    reg [WIDTH-1:0] flag_ff;
    wire [WIDTH-1:0] nxt_flag;
    assign nxt_flag = (flag_ff & ~clr_i) | set_i;
    assign flag_o = flag_ff;

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_ff <= {WIDTH{1'h0}};
        end else if (clk_en_i) begin
            flag_ff <= nxt_flag;
        end
    end

endmodule

`default_nettype wire

// file: dv/rpp_port_paging_assertions.sv
/* Port checks for the paging block.
   Assumes the block's clock and active-low reset, bound below. */
`timescale 1ns/1ps
`default_nettype none
module rpp_port_paging_assertions (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire clk_en_i,
    input wire [1:0] acc_src_i,
    input wire acc_rd_i,
    input wire acc_wr_i,
    input wire [7:0] acc_addr_i,
    input wire [7:0] acc_wdata_i,
    input wire [7:0] acc_rdata_o,
    input wire paged_hit_o,
    input wire [1:0] paged_wr_port_o,
    input wire paged_rd_port_o
);
default clocking @(posedge core_clk_i); endclocking
default disable iff (!rst_b_i);
wire rd = acc_rd_i && clk_en_i;
wire wr = acc_wr_i && clk_en_i;
wire [7:0] a = acc_addr_i;
a_hit_map: assert property (
    paged_hit_o == (a == 8'h4A || a == 8'h4B || (a >= 8'h4D && a <= 8'h7F)
    || (a >= 8'hD0 && a <= 8'hDF))) else $error("paged hit wrong");
a_unmapped_zero: assert property (
    rd && a == 8'h30 |=> acc_rdata_o == 8'h00) else $error("unmapped");
a_rdata_hold: assert property (
    !rd |=> $stable(acc_rdata_o)) else $error("read data moved");
a_phys_local: assert property (
    rd && a == 8'h4C && acc_src_i == 2'h0 |=> !acc_rdata_o[6])
    else $error("local phys port");
a_phys_remote: assert property (
    rd && a == 8'h4C && acc_src_i == 2'h2 |=> acc_rdata_o[6])
    else $error("remote phys port");
a_sel_readback: assert property (
    rd && a == 8'h4C |=> acc_rdata_o[4] == $past(paged_rd_port_o))
    else $error("read select view");
a_sts_port: assert property (
    rd && a == 8'h4D |=> acc_rdata_o[6] == $past(paged_rd_port_o))
    else $error("status port bit");
a_sel_write: assert property (
    wr && a == 8'h4C ##1 acc_src_i == $past(acc_src_i)
    |-> paged_rd_port_o == $past(acc_wdata_i[4])) else $error("sel write");
a_wr_idle: assert property (
    !(acc_wr_i && paged_hit_o) |-> paged_wr_port_o == 2'h0)
    else $error("write enable without paged write");
endmodule
bind rpp_port_paging rpp_port_paging_assertions i_chk (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
    .acc_src_i(acc_src_i), .acc_rd_i(acc_rd_i), .acc_wr_i(acc_wr_i),
    .acc_addr_i(acc_addr_i), .acc_wdata_i(acc_wdata_i),
    .acc_rdata_o(acc_rdata_o), .paged_hit_o(paged_hit_o),
    .paged_wr_port_o(paged_wr_port_o),
    .paged_rd_port_o(paged_rd_port_o));
`default_nettype wire

// file: dv/rpp_link_model.sv
/* Link-side model: per-port lock, pass and parity levels, error toggles.
   Assumes the bench changes it between clock edges. */
`timescale 1ns/1ps
`default_nettype none
module rpp_link_model (
    output logic [1:0] lock_o,
    output logic [1:0] pass_o,
    output logic [1:0] par_o,
    output logic [1:0] crc_o,
    output logic [1:0] seq_o
);
initial {lock_o, pass_o, par_o, crc_o, seq_o} = 10'h000;
// Errors are toggles, so two quick events never merge into one level.
task automatic err(input bit crc, input int p);
    if (crc) crc_o[p] = ~crc_o[p];
    else seq_o[p] = ~seq_o[p];
endtask
// Levels: kind 0 lock, kind 1 pass, any other kind parity over limit.
task automatic lvl(input int k, input int p, input bit v);
    if (k == 0) lock_o[p] = v;
    else if (k == 1) pass_o[p] = v;
    else par_o[p] = v;
endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
/* Bench for the paging block: register accesses and status events.
   Assumes the link model drives all status inputs. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
logic core_clk_i = 1'b0, rst_b_i = 1'b0, rd_s = 1'b0, wr_s = 1'b0, ce = 1'b1;
logic [1:0] src = 2'h0;
logic [7:0] addr = 8'h00, wd = 8'h00, wen_seen;
wire [7:0] rdata;
wire [1:0] wen, lk, ps, pr, cr, sq;
int n_mismatch = 0;
int checks = 0;
always #10 core_clk_i = ~core_clk_i;
rpp_link_model i_rpp_link_model (.lock_o(lk), .pass_o(ps), .par_o(pr),
    .crc_o(cr), .seq_o(sq));
rpp_port_paging i_rpp_port_paging (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .clk_en_i(ce),
    .acc_src_i(src), .acc_rd_i(rd_s), .acc_wr_i(wr_s), .acc_addr_i(addr),
    .acc_wdata_i(wd), .acc_rdata_o(rdata), .paged_hit_o(),
    .paged_wr_port_o(wen), .paged_rd_port_o(),
    .receiver_locked_i(lk), .port_pass_i(ps), .parity_over_limit_i(pr),
    .ctrl_channel_checksum_i(cr), .ctrl_channel_order_i(sq));
task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
        n_mismatch++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic acc(input logic [1:0] s, input bit w, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    src = s;
    addr = a;
    wd = d;
    rd_s = !w;
    wr_s = w;
    #1;
    wen_seen = {6'h00, wen};
    @(posedge core_clk_i);
    #1;
    rd_s = 1'b0;
    wr_s = 1'b0;
endtask
task automatic rd(input logic [1:0] s, input logic [7:0] a,
    input logic [7:0] exp, input logic [7:0] mask);
    acc(s, 1'b0, a, 8'h00);
    cmp(rdata & mask, exp);
endtask
task automatic results;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
initial begin
    repeat (16) @(posedge core_clk_i);
    #1 rst_b_i = 1'b1;
    rd(2'h0, 8'h4C, 8'h00, 8'hFF);
    rd(2'h1, 8'h4C, 8'h01, 8'h53);
    rd(2'h2, 8'h4C, 8'h52, 8'h52);
    rd(2'h0, 8'h30, 8'h00, 8'hFF);
    $display("test defaults done");
    for (int v = 0; v < 4; v++) begin
        acc(2'h0, 1'b1, 8'h4C, v[7:0]);
        acc(2'h0, 1'b1, 8'h60, 8'h5A);
        cmp(wen_seen, v[7:0]);
    end
    rd(2'h1, 8'h4C, 8'h01, 8'h53);
    rd(2'h0, 8'h4C, 8'h03, 8'hFF);
    rd(2'h3, 8'h4C, 8'h03, 8'hFF);
    ce = 1'b0;
    acc(2'h0, 1'b1, 8'h4C, 8'h10);
    ce = 1'b1;
    rd(2'h0, 8'h4C, 8'h03, 8'hFF);
    $display("test write enables done");
    i_rpp_link_model.lvl(0, 1, 1'b1);
    repeat (4) @(posedge core_clk_i);
    acc(2'h0, 1'b1, 8'h4C, 8'h10);
    rd(2'h0, 8'h4D, 8'h51, 8'hFF);
    rd(2'h0, 8'h4D, 8'h41, 8'hFF);
    $display("test lock done");
    i_rpp_link_model.err(1'b1, 0);
    i_rpp_link_model.err(1'b0, 0);
    i_rpp_link_model.err(1'b1, 1);
    i_rpp_link_model.err(1'b0, 1);
    i_rpp_link_model.lvl(1, 0, 1'b1);
    i_rpp_link_model.lvl(2, 0, 1'b1);
    repeat (4) @(posedge core_clk_i);
    acc(2'h0, 1'b1, 8'h4C, 8'h00);
    rd(2'h0, 8'h4D, 8'h2E, 8'hFF);
    rd(2'h0, 8'h4D, 8'h06, 8'hFF);
    rd(2'h2, 8'h4D, 8'h69, 8'hFF);
    rd(2'h2, 8'h4D, 8'h41, 8'hFF);
    // The event reaches the flag at the very edge that takes the read.
    i_rpp_link_model.err(1'b1, 1);
    @(posedge core_clk_i);
    rd(2'h2, 8'h4D, 8'h41, 8'hFF);
    rd(2'h2, 8'h4D, 8'h61, 8'hFF);
    i_rpp_link_model.lvl(2, 0, 1'b0);
    repeat (4) @(posedge core_clk_i);
    rd(2'h0, 8'h4D, 8'h02, 8'hFF);
    $display("test events done");
    results();
end
endmodule
`default_nettype wire
